/* src/adma_regs.vh */
// constants for the add-on fifo dma controller
//
// Function
// RL1 - transfer addresses are double-word aligned; low two address bits always zero
// RL2 - address register advances by four after each completed data phase
// RL3 - address register selected by decode 0/1, write-only, bits 20:2, resets zero
// RL4 - count holds bytes left, loaded as multiple of four, minus four per phase
// RL5 - count bit 24 selects transfer direction
// RL6 - all four byte lane enables active during every dma cycle
// RL7 - bus outputs float while the processor owns the bus
// RL8 - register select uses only the two upper decode bits
// RL9 - register access starts on strobe plus decode while grant is low
// RL10 - target fsm: write state with one ready clock, recovery, then idle
// RL11 - processor asserts last phase flag in single-cycle register access
// RL12 - request is inbound not-empty when direction one, outbound not-full when zero
// RL13 - requests ignored while count is zero
// RL14 - reads and writes share states; only write_not_read differs
// RL15 - on request assert hold, wait for grant, grant enables control outputs
// RL16 - address phase drives strobe and address, then enters phase by count left
// RL17 - last phase flag always asserted in final burst data state
// RL18 - first burst state waits ready only, then updates address and count; the code skips that update once loss is flagged
// RL19 - request loss sets flag that blocks fifo strobes and data movement
// RL20 - lost request in states two or three: finish, no update, last, recovery
// RL21 - otherwise states two and three complete on ready, update, advance
// RL22 - final state ignores loss, updates on ready, enters recovery
// RL23 - recovery waits ready idle, then address phase if request and count, else idle
// RL24 - bursts never exceed four data phases per address phase
// RL25 - all transitions on rising edge of the local bus clock
// RL26 - reset returns machines to idle, drops hold, clears both registers
// RL27 - each unstopped data phase strobes the selected fifo exactly once
`ifndef ADMA_REGS_VH
`define ADMA_REGS_VH
// -------------------------------------------------------------
// decode and fields
// -------------------------------------------------------------
`define ADMA_DEC_ADDR     2'b01
`define ADMA_DEC_COUNT    2'b10
`define ADMA_DEC_HI       21
`define ADMA_DEC_LO       20
`define ADMA_ADDR_HI      20
`define ADMA_ADDR_LO      2
`define ADMA_CNT_HI       17
`define ADMA_DIR_BIT      24
`define ADMA_ADDR_RST     32'h00000000
`define ADMA_CNT_RST      18'h00000
`define ADMA_STEP         18'h00004
`define ADMA_CNT_16       18'h00010
`define ADMA_CNT_12       18'h0000C
`define ADMA_CNT_8        18'h00008
`endif

/* src/adma_target.v */
// register write target state machine of the add-on dma controller
`include "adma_regs.vh"
module adma_target (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // local bus inputs
  input  wire        addr_strobe_n,
  input  wire        bus_grant,
  input  wire [31:0] bus_in,
  // register write strobes
  output reg         addr_we,
  output reg         cnt_we,
  output reg  [31:0] wdata,
  output reg         ready_out_n
);
  // -------------------------------------------------------------
  // states
  // -------------------------------------------------------------
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_ADDR = 2'b01;
  localparam [1:0] S_CNT  = 2'b10;
  localparam [1:0] S_REC  = 2'b11;
  reg  [1:0] state_q;
  wire [1:0] dec = bus_in[`ADMA_DEC_HI:`ADMA_DEC_LO];
  // a register write needs the data phase; data is sampled one clock after the strobe
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_q     <= S_IDLE;
      addr_we     <= 1'b0;
      cnt_we      <= 1'b0;
      wdata       <= 32'h00000000;
      ready_out_n <= 1'b1;
    end
    else
    begin
      addr_we <= 1'b0;
      cnt_we  <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (!addr_strobe_n && !bus_grant && dec == `ADMA_DEC_ADDR) // [RL9] [RL8]
          begin
            state_q     <= S_ADDR;
            ready_out_n <= 1'b0;
          end
          else if (!addr_strobe_n && !bus_grant && dec == `ADMA_DEC_COUNT) // [RL9] [RL8]
          begin
            state_q     <= S_CNT;
            ready_out_n <= 1'b0;
          end
        end
        S_ADDR:
        begin
          addr_we     <= 1'b1; // [RL10]
          wdata       <= bus_in;
          ready_out_n <= 1'b1;
          state_q     <= S_REC;
        end
        S_CNT:
        begin
          cnt_we      <= 1'b1; // [RL10]
          wdata       <= bus_in;
          ready_out_n <= 1'b1;
          state_q     <= S_REC;
        end
        S_REC:
          state_q <= S_IDLE; // [RL10]
        default:
          state_q <= S_IDLE;
      endcase
    end
  end
endmodule

/* src/adma_ctrl.v */
// add-on fifo dma controller top: registers and bus master machine
`include "adma_regs.vh"
module adma_ctrl (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // add-on bus, shared lines split into in, out, enable (low = driving)
  input  wire [31:0] addr_data_in,
  output reg  [31:0] addr_data_out,
  output reg         addr_data_oe_n,
  input  wire        addr_strobe_n_in,
  output reg         addr_strobe_n_out,
  output reg         ctrl_oe_n,
  output reg         write_not_read_out,
  output reg         last_phase_flag_n,
  output reg  [3:0]  byte_lane_enables_n,
  input  wire        ready_in_n,
  output reg         ready_out_n,
  // arbitration
  output reg         hold_req,
  input  wire        bus_grant,
  // bridge fifo
  input  wire        inbound_fifo_empty,
  input  wire        outbound_fifo_full_req,
  output reg         fifo_pop_strobe_n,
  output reg         fifo_push_strobe_n
);
  // -------------------------------------------------------------
  // master states
  // -------------------------------------------------------------
  localparam [2:0] M_IDLE = 3'd0;
  localparam [2:0] M_HOLD = 3'd1;
  localparam [2:0] M_ADDR = 3'd2;
  localparam [2:0] M_D1   = 3'd3;
  localparam [2:0] M_D2   = 3'd4;
  localparam [2:0] M_D3   = 3'd5;
  localparam [2:0] M_D4   = 3'd6;
  localparam [2:0] M_REC  = 3'd7;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [18:0] addr_q;
  reg  [17:0] cnt_q;
  reg         dir_q;
  reg         lost_q;
  wire        addr_we;
  wire        cnt_we;
  wire [31:0] wdata;
  wire        ready_t_n;

  // -------------------------------------------------------------
  // register target
  // -------------------------------------------------------------
  adma_target u_target (
    .clk_sys       (clk_sys),
    .rstn          (rstn),
    .addr_strobe_n (addr_strobe_n_in),
    .bus_grant     (bus_grant),
    .bus_in        (addr_data_in),
    .addr_we       (addr_we),
    .cnt_we        (cnt_we),
    .wdata         (wdata),
    .ready_out_n   (ready_t_n)
  );

  // -------------------------------------------------------------
  // request and phase decisions
  // -------------------------------------------------------------
  // direction one drains the inbound fifo, zero fills the outbound one
  wire req      = dir_q ? !inbound_fifo_empty : !outbound_fifo_full_req; // [RL12]
  wire done     = (cnt_q == `ADMA_CNT_RST);
  wire rdy      = !ready_in_n;
  wire in_data  = (state_q == M_D1) || (state_q == M_D2) || (state_q == M_D3) || (state_q == M_D4);
  // final phase ignores loss: it always moves its word
  wire moving   = (state_q == M_D4) || (in_data && !lost_q); // [RL22]
  wire complete = in_data && rdy && moving; // [RL2] [RL4]
  wire going_last = ((state_q == M_D2) || (state_q == M_D3)) && lost_q && rdy;

  always @*
  begin
    state_d = state_q;
    case (state_q)
      M_IDLE:
        if (req && !done) // [RL13]
          state_d = M_HOLD;
      M_HOLD:
        if (bus_grant) // [RL15]
          state_d = M_ADDR;
      M_ADDR:
      begin
        // at most four phases per address phase keeps bursts legal
        if (cnt_q >= `ADMA_CNT_16) // [RL16] [RL24]
          state_d = M_D1;
        else if (cnt_q == `ADMA_CNT_12)
          state_d = M_D2;
        else if (cnt_q == `ADMA_CNT_8)
          state_d = M_D3;
        else
          state_d = M_D4;
      end
      M_D1:
        if (rdy) // [RL18]
          state_d = M_D2;
      M_D2:
        if (rdy)
          state_d = lost_q ? M_REC : M_D3; // [RL20] [RL21]
      M_D3:
        if (rdy)
          state_d = lost_q ? M_REC : M_D4; // [RL20] [RL21]
      M_D4:
        if (rdy) // [RL22]
          state_d = M_REC;
      M_REC:
        if (!rdy)
          state_d = (req && !done) ? M_ADDR : M_IDLE; // [RL23]
      default:
        state_d = M_IDLE;
    endcase
  end

  // -------------------------------------------------------------
  // master state
  // -------------------------------------------------------------
  always @(posedge clk_sys) // [RL25]
  begin
    if (!rstn) // [RL26]
    begin
      state_q <= M_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // -------------------------------------------------------------
  // address register
  // -------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rstn) // [RL26]
    begin
      addr_q <= 19'h00000;
    end
    else if (addr_we)
    begin
      addr_q <= wdata[`ADMA_ADDR_HI:`ADMA_ADDR_LO]; // [RL3] [RL1]
    end
    else if (complete)
    begin
      addr_q <= addr_q + 19'h00001; // [RL2]
    end
  end

  // -------------------------------------------------------------
  // count register and direction
  // -------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rstn) // [RL26]
    begin
      cnt_q <= `ADMA_CNT_RST;
      dir_q <= 1'b0;
    end
    else if (cnt_we)
    begin
      cnt_q <= {wdata[`ADMA_CNT_HI:2], 2'b00}; // [RL4]
      dir_q <= wdata[`ADMA_DIR_BIT]; // [RL5]
    end
    else if (complete)
    begin
      cnt_q <= cnt_q - `ADMA_STEP; // [RL4]
    end
  end

  // -------------------------------------------------------------
  // request loss
  // -------------------------------------------------------------
  // loss is caught in data states and cleared at address, recovery and idle
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      lost_q <= 1'b0;
    end
    else if (state_q == M_ADDR || state_q == M_REC || state_q == M_IDLE)
    begin
      lost_q <= 1'b0;
    end
    else if (in_data && !req)
    begin
      lost_q <= 1'b1; // [RL19]
    end
  end

  // -------------------------------------------------------------
  // next-cycle output terms
  // -------------------------------------------------------------
  wire owner_d   = (state_d != M_IDLE) && (state_d != M_HOLD) && bus_grant;
  wire data_d    = (state_d == M_D1) || (state_d == M_D2) || (state_d == M_D3) || (state_d == M_D4);
  // the fifo steps on the strobe's rising edge, so each phase's pulse ends at its ready edge;
  // a zero-wait target would need the synchronous fifo mode instead
  wire strobe_d  = data_d && !(in_data && rdy) &&
                   (state_d == M_D4 || (!lost_q && req));
  wire last_d    = (state_d == M_D4) || (data_d && going_last) ||
                   ((state_d == M_D2 || state_d == M_D3) && lost_q);

  // -------------------------------------------------------------
  // arbitration and bus ownership
  // -------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      hold_req <= 1'b0;
    end
    else
    begin
      hold_req <= (state_d != M_IDLE); // [RL15]
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ctrl_oe_n <= 1'b1;
    end
    else
    begin
      ctrl_oe_n <= !owner_d; // [RL7] [RL15]
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      byte_lane_enables_n <= 4'hF;
    end
    else
    begin
      byte_lane_enables_n <= owner_d ? 4'h0 : 4'hF; // [RL6]
    end
  end

  // -------------------------------------------------------------
  // address phase
  // -------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      addr_data_oe_n <= 1'b1;
    end
    else
    begin
      addr_data_oe_n <= !(owner_d && state_d == M_ADDR); // [RL16] [RL7]
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      addr_data_out <= 32'h00000000;
    end
    else
    begin
      addr_data_out <= {11'h000, (state_d == M_ADDR && complete) ? addr_q + 19'h00001 : addr_q,
                        2'b00}; // [RL1]
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      addr_strobe_n_out <= 1'b1;
    end
    else
    begin
      addr_strobe_n_out <= !(state_d == M_ADDR); // [RL16]
    end
  end

  // -------------------------------------------------------------
  // data phase
  // -------------------------------------------------------------
  // fifo to memory is an add-on write; same states either way
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      write_not_read_out <= 1'b0;
    end
    else
    begin
      write_not_read_out <= dir_q; // [RL14]
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      last_phase_flag_n <= 1'b1;
    end
    else
    begin
      last_phase_flag_n <= !last_d; // [RL17] [RL20]
    end
  end

  // -------------------------------------------------------------
  // register answer
  // -------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ready_out_n <= 1'b1;
    end
    else
    begin
      ready_out_n <= ready_t_n; // [RL10]
    end
  end

  // -------------------------------------------------------------
  // fifo strobes
  // -------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      fifo_pop_strobe_n <= 1'b1;
    end
    else
    begin
      fifo_pop_strobe_n <= !(strobe_d && dir_q); // [RL27] [RL19]
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      fifo_push_strobe_n <= 1'b1;
    end
    else
    begin
      fifo_push_strobe_n <= !(strobe_d && !dir_q); // [RL27] [RL19]
    end
  end
endmodule

/* verification/adma_chk_asserts.sv */
// port checker for the add-on fifo dma controller
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module adma_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [31:0] addr_data_in,
  input wire logic [31:0] addr_data_out,
  input wire logic        addr_data_oe_n,
  input wire logic        addr_strobe_n_in,
  input wire logic        addr_strobe_n_out,
  input wire logic        ctrl_oe_n,
  input wire logic        write_not_read_out,
  input wire logic [3:0]  byte_lane_enables_n,
  input wire logic        ready_in_n,
  input wire logic        ready_out_n,
  input wire logic        bus_grant,
  input wire logic        fifo_pop_strobe_n,
  input wire logic        fifo_push_strobe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire hold_q_n_ok = !(ctrl_oe_n && addr_data_oe_n && ready_out_n && fifo_pop_strobe_n);
  property p_rst; disable iff (1'h0) !rstn |=> !hold_q_n_ok; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_float; !bus_grant && !$past(bus_grant) |-> ctrl_oe_n && addr_data_oe_n; endproperty
  a_float: assert property (p_float) else $error("bus driven while not owner");
  property p_be; !ctrl_oe_n |-> byte_lane_enables_n == 4'h0; endproperty
  a_be: assert property (p_be) else $error("byte lanes not all enabled");
  wire dec_ok = addr_data_in[21:20] == 2'h1 || addr_data_in[21:20] == 2'h2;
  property p_reg; !addr_strobe_n_in && !bus_grant && dec_ok |-> ##[1:3] !ready_out_n; endproperty
  a_reg: assert property (p_reg) else $error("register write not answered");
  property p_ref; !addr_strobe_n_in && !bus_grant && !dec_ok |-> ##1 ready_out_n [*3]; endproperty
  a_ref: assert property (p_ref) else $error("foreign decode answered");
  property p_rdy; $fell(ready_out_n) |=> ready_out_n; endproperty
  a_rdy: assert property (p_rdy) else $error("ready longer than one cycle");
  property p_ads; $fell(addr_strobe_n_out) |=> addr_strobe_n_out; endproperty
  a_ads: assert property (p_ads) else $error("address strobe too long");
  property p_align; !addr_strobe_n_out |-> addr_data_out[1:0] == 2'h0 && !addr_data_oe_n && !ctrl_oe_n; endproperty
  a_align: assert property (p_align) else $error("bad address phase");
  property p_pop; !fifo_pop_strobe_n |-> fifo_push_strobe_n && write_not_read_out; endproperty
  a_pop: assert property (p_pop) else $error("pop in wrong direction");
  property p_push; !fifo_push_strobe_n |-> !write_not_read_out; endproperty
  a_push: assert property (p_push) else $error("push in wrong direction");
  property p_pulse; (!fifo_pop_strobe_n || !fifo_push_strobe_n) && !ready_in_n |=>
    fifo_pop_strobe_n && fifo_push_strobe_n; endproperty
  a_pulse: assert property (p_pulse) else $error("fifo strobe not ended at ready");
endmodule
bind adma_ctrl adma_chk adma_chk_i (.*);

/* verification/adma_host.sv */
// processor and memory model: grants the bus and ends data phases
module adma_host (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic hold_req,
  input  wire logic addr_strobe_n_out,
  input  wire logic ctrl_oe_n,
  input  wire logic last_phase_flag_n,
  output logic      bus_grant,
  output logic      ready_in_n
);
  logic       busy;
  logic       slow;
  logic [3:0] n;
  // every other phase waits three cycles, so prompt and slow answers mix
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      bus_grant <= #1 1'h0;
      ready_in_n <= #1 1'h1;
      busy <= #1 1'h0;
      slow <= #1 1'h0;
      n <= #1 4'h0;
    end
    else
    begin
      bus_grant <= #1 hold_req;
      if (!addr_strobe_n_out && !ctrl_oe_n)
        busy <= #1 1'h1;
      if (!ready_in_n)
      begin
        ready_in_n <= #1 1'h1;
        n <= #1 4'h0;
        slow <= #1 !slow;
        if (!last_phase_flag_n)
          busy <= #1 1'h0;
      end
      else if (busy && n == (slow ? 4'h3 : 4'h0))
        ready_in_n <= #1 1'h0;
      else if (busy)
        n <= #1 n + 4'h1;
    end
  end
endmodule

/* verification/tb.sv */
// register and transfer tests of the add-on fifo dma controller
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin $display("CHECK FAILED t=%0t got=%0h exp=%0h", \
  $time, a, b); n_errors++; end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 1'h0, rstn = 1'h0, tb_ads = 1'h1, empty = 1'h1, full = 1'h1, wnr;
  logic [31:0] tb_ad = 32'h0, last_a;
  int          n_errors = 0, cmp_count = 0, pops, pushes, naph, lose_at = 0;
  wire [31:0]  addr_data_out;
  wire [3:0]   byte_lane_enables_n;
  wire         addr_data_oe_n, addr_strobe_n_out, ctrl_oe_n, write_not_read_out, last_phase_flag_n;
  wire         ready_in_n, ready_out_n, hold_req, bus_grant, fifo_pop_strobe_n, fifo_push_strobe_n;
  wire [31:0]  ad_w = addr_data_oe_n ? tb_ad : addr_data_out;
  wire         ads_w = ctrl_oe_n ? tb_ads : addr_strobe_n_out;
  always #5 clk_sys = ~clk_sys;
  adma_ctrl adma_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .addr_data_in(ad_w), .addr_data_out(addr_data_out),
    .addr_data_oe_n(addr_data_oe_n), .addr_strobe_n_in(ads_w), .addr_strobe_n_out(addr_strobe_n_out),
    .ctrl_oe_n(ctrl_oe_n), .write_not_read_out(write_not_read_out), .last_phase_flag_n(last_phase_flag_n),
    .byte_lane_enables_n(byte_lane_enables_n), .ready_in_n(ready_in_n), .ready_out_n(ready_out_n),
    .hold_req(hold_req), .bus_grant(bus_grant), .inbound_fifo_empty(empty), .outbound_fifo_full_req(full),
    .fifo_pop_strobe_n(fifo_pop_strobe_n), .fifo_push_strobe_n(fifo_push_strobe_n));
  adma_host adma_host_i (.clk_sys(clk_sys), .rstn(rstn), .hold_req(hold_req), .addr_strobe_n_out(addr_strobe_n_out),
    .ctrl_oe_n(ctrl_oe_n), .last_phase_flag_n(last_phase_flag_n), .bus_grant(bus_grant), .ready_in_n(ready_in_n));
  // a word moves where a fifo strobe meets a ready edge
  always @(posedge clk_sys)
  begin
    if (!fifo_pop_strobe_n && !ready_in_n)
      pops++;
    if (!fifo_push_strobe_n && !ready_in_n)
      pushes++;
    if (!addr_strobe_n_out && !addr_data_oe_n)
    begin
      last_a = addr_data_out;
      wnr = write_not_read_out;
      naph++;
    end
    if (lose_at != 0 && pops == lose_at)
    begin
      lose_at = 0;
      empty <= #1 1'h1;
    end
  end
  // only while the processor owns the bus, spaced five cycles
  task wr(input logic [1:0] dec, input logic [31:0] d, input logic exp);
    logic seen;
    begin
      seen = 1'h0;
      @(posedge clk_sys);
      #1 tb_ads = 1'h0;
      tb_ad = {10'h000, dec, 20'h00000};
      @(posedge clk_sys);
      #1 tb_ads = 1'h1; // single data phase, so it is the last one
      tb_ad = d;
      repeat (3)
      begin
        @(posedge clk_sys);
        #1 seen = seen | (ready_out_n === 1'h0);
      end
      tb_ad = ~d;
      `CHK(seen, exp)
    end
  endtask
  task wait_idle;
    int i;
    begin
      i = 0;
      while (hold_req !== 1'h1 && i < 300)
      begin
        @(posedge clk_sys);
        #1 i++;
      end
      while (hold_req !== 1'h0 && i < 600)
      begin
        @(posedge clk_sys);
        #1 i++;
      end
      `CHK(i < 600, 1'h1)
    end
  endtask
  task clr;
    pops = 0;
    pushes = 0;
    naph = 0;
  endtask
  task results;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // the tests need a few hundred cycles; this leaves wide margin
  initial
  begin
    #100000 n_errors++;
    results();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    #1 rstn = 1'h1;
    `CHK({hold_req, ctrl_oe_n, addr_data_oe_n, byte_lane_enables_n, ready_out_n}, 8'h7F)
    empty = 1'h0;
    wr(2'h1, 32'h00000100, 1'h1);
    wr(2'h2, 32'h01000000, 1'h1);
    wr(2'h3, 32'h00000040, 1'h0);
    repeat (20) @(posedge clk_sys);
    `CHK(hold_req, 1'h0)
    $display("test zero_count done");
    clr();
    wr(2'h2, 32'h01000018, 1'h1);
    wait_idle();
    `CHK(pops, 6)
    `CHK(pushes, 0)
    `CHK(naph, 2)
    `CHK(last_a, 32'h00000110)
    `CHK(wnr, 1'h1)
    $display("test inbound_burst done");
    clr();
    empty = 1'h1;
    full = 1'h0;
    wr(2'h1, 32'h00000200, 1'h1);
    wr(2'h2, 32'h00000008, 1'h1);
    wait_idle();
    `CHK(pushes, 2)
    `CHK(wnr, 1'h0)
    `CHK(last_a, 32'h00000200)
    full = 1'h1;
    $display("test outbound_burst done");
    clr();
    wr(2'h1, 32'h00000300, 1'h1);
    wr(2'h2, 32'h01000010, 1'h1);
    lose_at = 2;
    empty = 1'h0;
    wait_idle();
    `CHK(pops, 2)
    `CHK(naph, 1)
    empty = 1'h0;
    wait_idle();
    `CHK(pops, 4)
    `CHK(last_a, 32'h00000308)
    $display("test request_lost done");
    results();
  end
endmodule
